// file: include/epr_pkg.sv
// epr_pkg: constants for exception priority and reset control
package epr_pkg;
   // exception vectors
   localparam logic [7:0] VEC_DEBUG = 8'h01;
   localparam logic [7:0] VEC_NMI = 8'h02;
   localparam logic [7:0] VEC_INVOP = 8'h06;
   localparam logic [7:0] VEC_NODEV = 8'h07;
   localparam logic [7:0] VEC_DFAULT = 8'h08;
   localparam logic [7:0] VEC_TSS = 8'h0A;
   localparam logic [7:0] VEC_SEGNP = 8'h0B;
   localparam logic [7:0] VEC_GP = 8'h0D;
   localparam logic [7:0] VEC_PAGE = 8'h0E;
   localparam logic [7:0] VEC_COPERR = 8'h10;
   localparam logic [4:0] MAX_INSTR_LEN = 5'h0F;
   // reset values
   localparam logic [31:0] RST_IP = 32'h0000FFF0;
   localparam logic [15:0] RST_CS_SEL = 16'hF000;
   localparam logic [31:0] RST_CS_BASE = 32'hFFFF0000;
   localparam logic [31:0] RST_SEG_LIMIT = 32'h0000FFFF;
   localparam logic [15:0] RST_DATA_SEL = 16'h0000;
   localparam logic [31:0] RST_FLAGS = 32'h00000002;
   localparam logic [23:0] RST_FETCH = 24'hFFFFF0;
   localparam int FLAG_IF = 9;
   localparam int FLAG_ONE = 1;
   // control register fields
   localparam int CTL_TS = 0;
   localparam int CTL_MP = 1;
   localparam int CTL_EM = 2;
   localparam int CTL_PROT = 3;
   localparam int CTL_V86 = 4;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IP = 8'h0C;
   localparam logic [7:0] ADDR_CS_SEL = 8'h10;
   localparam logic [7:0] ADDR_CS_BASE = 8'h14;
   localparam logic [7:0] ADDR_CS_LIM = 8'h18;
   localparam logic [7:0] ADDR_DATA_SEL = 8'h1C;
   localparam logic [7:0] ADDR_DATA_LIM = 8'h20;
   localparam logic [7:0] ADDR_ACC = 8'h24;
   localparam logic [7:0] ADDR_EXTD = 8'h28;
   // timing: core clock is the double-rate clock
   localparam int CLK_NS = 40;
   localparam int DOUBLE_RATE_CLOCK_NS = 40;
   localparam int START_MIN_DOUBLE_RATE_CLOCK = 350;
   localparam int START_MAX_DOUBLE_RATE_CLOCK = 450;
   localparam int START_CYC = ((START_MIN_DOUBLE_RATE_CLOCK + START_MAX_DOUBLE_RATE_CLOCK) / 2 * DOUBLE_RATE_CLOCK_NS) / CLK_NS;
   localparam int BIST_CLKS = 1048576;
   typedef enum logic [1:0] {
      SQ_WAIT = 2'b00,
      SQ_BIST = 2'b01,
      SQ_DELAY = 2'b10,
      SQ_RUN = 2'b11
   } epr_seq_e;
endpackage : epr_pkg

// file: include/epr_seq_if.sv
// epr_seq_if: link between the controller and its start-up sequencer
`timescale 1ns/1ps
interface epr_seq_if;
   logic strap_busy_n;
   logic exec_ok;
   logic bist_run;
   logic bist_done;
   modport seq (input strap_busy_n, output exec_ok, output bist_run, output bist_done);
   modport ctl (output strap_busy_n, input exec_ok, input bist_run, input bist_done);
endinterface : epr_seq_if

// file: src/epr_seq.sv
// epr_seq: start-up delay and self-test sequencer
`timescale 1ns/1ps
module epr_seq #(
   parameter int unsigned BIST_CYCLES = epr_pkg::BIST_CLKS
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   epr_seq_if.seq sq
);
   localparam logic [20:0] BIST_LAST = 21'(BIST_CYCLES - 1);
   localparam logic [20:0] DLY_LAST = 21'(epr_pkg::START_CYC - 1);
   epr_pkg::epr_seq_e st;
   epr_pkg::epr_seq_e next_st;
   logic [20:0] cnt;
   logic [20:0] next_cnt;
   logic [8:0] dly_seen;
   wire cnt_zero = (cnt == 21'h000000);

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_cnt = cnt - 21'h000001;
      case (st)
         epr_pkg::SQ_WAIT: begin
            // strap taken at the first edge after release
            next_st = sq.strap_busy_n ? epr_pkg::SQ_DELAY : epr_pkg::SQ_BIST;
            next_cnt = sq.strap_busy_n ? DLY_LAST : BIST_LAST;
         end
         epr_pkg::SQ_BIST: begin
            if (cnt_zero) begin
               // self-test over: behave as a fresh reset
               next_st = epr_pkg::SQ_DELAY;
               next_cnt = DLY_LAST;
            end
         end
         epr_pkg::SQ_DELAY: begin
            if (cnt_zero) begin
               next_st = epr_pkg::SQ_RUN;
            end
         end
         epr_pkg::SQ_RUN: begin
            next_cnt = cnt;
         end
         default: begin
            next_st = epr_pkg::SQ_WAIT;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= epr_pkg::SQ_WAIT;
         cnt <= 21'h000000;
         sq.exec_ok <= 1'b0;
         sq.bist_run <= 1'b0;
         sq.bist_done <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         sq.exec_ok <= (next_st == epr_pkg::SQ_RUN);
         sq.bist_run <= (next_st == epr_pkg::SQ_BIST);
         sq.bist_done <= (st == epr_pkg::SQ_BIST) && cnt_zero;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dly_seen <= 9'h000;
      end else if (st != epr_pkg::SQ_DELAY) begin
         dly_seen <= 9'h000;
      end else begin
         dly_seen <= dly_seen + 9'h001;
      end
   end

   start_delay_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(sq.exec_ok) |-> (dly_seen == 9'(epr_pkg::START_CYC)))
      else $error("start delay length wrong");
endmodule : epr_seq

// file: src/epr_ctrl.sv
// epr_ctrl: interrupt and exception priority with reset control
// Function
// - sample request inputs only at instruction boundaries
// - non-maskable before maskable at same boundary
// - maskable after non-maskable only if enabled
// - debug trap, external requests, then debug fault
// - fetch segment faults, then fetch page faults
// - decode: vector 6 or 13 faults
// - wait opcode: vector 7 if switched and monitor
// - escape opcode: vector 7 if emulate or switched
// - wait or escape: vector 16 on coprocessor error
// - per reference: segment faults before page faults
// - faults leave the instruction restartable
// - two named cases need not be restartable
// - nested non-page fault during segment fault: 8
// - any nested fault during page fault: 8
// - code pointer, selector, base, limit reset values
// - data selector zero, data limit 64K
// - flag word resets to 0002, bit1 one
// - extended data register holds component identifier
// - first fetch at top; far jump lowers upper lines
// - no instruction or dispatch during reset
// - start 350 to 450 double-rate clocks later
// - busy low at release runs self-test first
// - non-maskable uses vector 2, no acknowledge
// - non-maskable handler blocks requests, latches repeat
`timescale 1ns/1ps
module epr_ctrl #(
   parameter int unsigned BIST_CYCLES = epr_pkg::BIST_CLKS,
   parameter logic [31:0] COMP_STEP_ID = 32'h00005A01 // arbitrary value
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic maskable_irq_in_i,
   input wire logic nmi_i,
   input wire logic [7:0] irq_vector_i,
   input wire logic coproc_error_n_i,
   input wire logic coproc_busy_n_i,
   input wire logic selftest_flaw_i,
   input wire logic boundary_i,
   input wire logic dbg_trap_i,
   input wire logic dbg_fault_i,
   input wire logic fetch_seg_fault_i,
   input wire logic fetch_seg_np_i,
   input wire logic fetch_page_fault_i,
   input wire logic illegal_op_i,
   input wire logic prot_only_i,
   input wire logic [4:0] instr_len_i,
   input wire logic priv_viol_i,
   input wire logic wait_op_i,
   input wire logic coproc_escape_op_i,
   input wire logic mem_seg_fault_i,
   input wire logic [7:0] mem_seg_vec_i,
   input wire logic mem_page_fault_i,
   input wire logic irq_return_op_i,
   input wire logic far_jump_i,
   input wire logic nested_exc_i,
   input wire logic [7:0] nested_vec_i,
   input wire logic handler_entered_i,
   input wire logic tss_partial_i,
   input wire logic coproc_wrap_i,
   output logic dispatch_o,
   output logic [7:0] vector_o,
   output logic intack_o,
   output logic restartable_o,
   output logic exec_enable_o,
   output logic bist_run_o,
   output logic upper_addr_low_o,
   output logic [23:0] fetch_addr_o
);
   localparam logic [1:0] CLS_NONE = 2'h0;
   localparam logic [1:0] CLS_SEG = 2'h1;
   localparam logic [1:0] CLS_PAGE = 2'h2;

   logic [4:0] ctrl;
   logic [31:0] flag_word;
   logic [31:0] accumulator_reg;
   logic nmi_active;
   logic nmi_pend;
   logic nmi_last;
   logic [1:0] disp_class;

   epr_seq_if sq ();

   assign sq.strap_busy_n = coproc_busy_n_i;

   epr_seq #(
      .BIST_CYCLES(BIST_CYCLES)
   ) u_seq (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .sq(sq)
   );

   // ----------------------------------------
   // register bus decode
   // ----------------------------------------
   wire setup = psel_i & ~penable_i;
   wire wr_go = psel_i & penable_i & pready_o & pwrite_i;
   wire hit = (paddr_i[1:0] == 2'h0) && (paddr_i <= epr_pkg::ADDR_EXTD);
   wire [31:0] status_word = {16'h0000, vector_o, 1'b0, disp_class, upper_addr_low_o,
                              nmi_pend, nmi_active, sq.bist_run, sq.exec_ok};
   wire [31:0] rd_val =
      (paddr_i == epr_pkg::ADDR_CTRL) ? {27'h0000000, ctrl} :
      (paddr_i == epr_pkg::ADDR_FLAGS) ? flag_word :
      (paddr_i == epr_pkg::ADDR_STATUS) ? status_word :
      (paddr_i == epr_pkg::ADDR_IP) ? epr_pkg::RST_IP :
      (paddr_i == epr_pkg::ADDR_CS_SEL) ? {16'h0000, epr_pkg::RST_CS_SEL} :
      (paddr_i == epr_pkg::ADDR_CS_BASE) ? epr_pkg::RST_CS_BASE :
      (paddr_i == epr_pkg::ADDR_CS_LIM) ? epr_pkg::RST_SEG_LIMIT :
      (paddr_i == epr_pkg::ADDR_DATA_SEL) ? {16'h0000, epr_pkg::RST_DATA_SEL} :
      (paddr_i == epr_pkg::ADDR_DATA_LIM) ? epr_pkg::RST_SEG_LIMIT :
      (paddr_i == epr_pkg::ADDR_ACC) ? accumulator_reg :
      (paddr_i == epr_pkg::ADDR_EXTD) ? COMP_STEP_ID :
      32'h00000000;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         // one wait-free access phase after each setup
         pready_o <= setup;
         pslverr_o <= setup & ~hit;
         prdata_o <= (setup & ~pwrite_i) ? rd_val : 32'h00000000;
      end
   end

   // ----------------------------------------
   // exception and request detection
   // ----------------------------------------
   wire exec_ok = sq.exec_ok;
   wire evt_ok = boundary_i & exec_ok;
   wire nmi_new = nmi_i & ~nmi_last;
   wire nmi_take = (nmi_new | nmi_pend) & ~nmi_active;
   wire maskable_irq_in_take = maskable_irq_in_i & flag_word[epr_pkg::FLAG_IF] & ~nmi_active;
   wire dec_ud = illegal_op_i | (prot_only_i & (~ctrl[epr_pkg::CTL_PROT] | ctrl[epr_pkg::CTL_V86]));
   wire dec_gp = (instr_len_i > epr_pkg::MAX_INSTR_LEN) | priv_viol_i;
   wire wait_nm = wait_op_i & ctrl[epr_pkg::CTL_TS] & ctrl[epr_pkg::CTL_MP];
   wire esc_nm = coproc_escape_op_i & (ctrl[epr_pkg::CTL_EM] | ctrl[epr_pkg::CTL_TS]);
   wire cop_err = (wait_op_i | coproc_escape_op_i) & ~coproc_error_n_i;
   wire any_evt = dbg_trap_i | nmi_take | maskable_irq_in_take | dbg_fault_i | fetch_seg_fault_i
                  | fetch_page_fault_i | dec_ud | dec_gp | wait_nm | esc_nm | cop_err
                  | mem_seg_fault_i | mem_page_fault_i;
   wire nmi_go = evt_ok & ~dbg_trap_i & nmi_take;
   wire maskable_irq_in_go = evt_ok & ~dbg_trap_i & ~nmi_take & maskable_irq_in_take;
   wire is_fault = ~dbg_trap_i & ~nmi_take & ~maskable_irq_in_take;

   // highest pending event wins
   wire [7:0] sel_vec =
      dbg_trap_i ? epr_pkg::VEC_DEBUG :
      nmi_take ? epr_pkg::VEC_NMI :
      maskable_irq_in_take ? irq_vector_i :
      dbg_fault_i ? epr_pkg::VEC_DEBUG :
      fetch_seg_fault_i ? (fetch_seg_np_i ? epr_pkg::VEC_SEGNP : epr_pkg::VEC_GP) :
      fetch_page_fault_i ? epr_pkg::VEC_PAGE :
      dec_ud ? epr_pkg::VEC_INVOP :
      dec_gp ? epr_pkg::VEC_GP :
      (wait_nm | esc_nm) ? epr_pkg::VEC_NODEV :
      cop_err ? epr_pkg::VEC_COPERR :
      mem_seg_fault_i ? mem_seg_vec_i :
      epr_pkg::VEC_PAGE;

   // a fault raised while a handler is being entered
   wire take_nested = nested_exc_i & exec_ok & (disp_class != CLS_NONE);
   wire dbl = (disp_class == CLS_PAGE)
              | (nested_vec_i != epr_pkg::VEC_PAGE);
   wire [7:0] nest_vec = dbl ? epr_pkg::VEC_DFAULT : nested_vec_i;
   wire next_disp = take_nested | (evt_ok & any_evt);
   wire [7:0] next_vec = take_nested ? nest_vec : sel_vec;
   wire vec_seg = (next_vec >= epr_pkg::VEC_TSS) && (next_vec <= epr_pkg::VEC_GP);
   wire [1:0] next_class = ~next_disp ? disp_class :
                           vec_seg ? CLS_SEG :
                           (next_vec == epr_pkg::VEC_PAGE) ? CLS_PAGE : CLS_NONE;
   wire no_restart = tss_partial_i | coproc_wrap_i;

   // ----------------------------------------
   // dispatch outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dispatch_o <= 1'b0;
         vector_o <= 8'h00;
         intack_o <= 1'b0;
         restartable_o <= 1'b0;
      end else begin
         dispatch_o <= next_disp;
         intack_o <= maskable_irq_in_go & ~take_nested;
         if (next_disp) begin
            vector_o <= next_vec;
            restartable_o <= (take_nested | is_fault) & ~no_restart;
         end
      end
   end

   // ----------------------------------------
   // handler state
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nmi_active <= 1'b0;
         nmi_pend <= 1'b0;
         nmi_last <= 1'b0;
         disp_class <= CLS_NONE;
      end else begin
         // a rise is remembered here and acted on only at a boundary
         nmi_last <= nmi_i;
         if (nmi_go & ~take_nested) begin
            nmi_pend <= 1'b0;
         end else if (nmi_new) begin
            nmi_pend <= 1'b1;
         end
         if (nmi_go & ~take_nested) begin
            nmi_active <= 1'b1;
         end else if (irq_return_op_i) begin
            nmi_active <= 1'b0;
         end
         if (next_disp) begin
            disp_class <= next_class;
         end else if (handler_entered_i) begin
            disp_class <= CLS_NONE;
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl <= 5'h00;
         flag_word <= epr_pkg::RST_FLAGS;
      end else begin
         if (wr_go && paddr_i == epr_pkg::ADDR_CTRL) begin
            ctrl <= pwdata_i[4:0];
         end
         if (wr_go && paddr_i == epr_pkg::ADDR_FLAGS) begin
            flag_word <= pwdata_i;
            flag_word[epr_pkg::FLAG_ONE] <= 1'b1;
         end
         if (nmi_go & ~take_nested) begin
            flag_word[epr_pkg::FLAG_IF] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // reset and start-up results
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         accumulator_reg <= 32'h00000000;
         exec_enable_o <= 1'b0;
         bist_run_o <= 1'b0;
         upper_addr_low_o <= 1'b0;
         fetch_addr_o <= epr_pkg::RST_FETCH;
      end else begin
         if (sq.bist_done) begin
            accumulator_reg <= {31'h00000000, selftest_flaw_i};
         end
         exec_enable_o <= exec_ok;
         bist_run_o <= sq.bist_run;
         if (exec_ok & far_jump_i) begin
            upper_addr_low_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_both_req;
      evt_ok & ~take_nested & ~dbg_trap_i & nmi_take & maskable_irq_in_take;
   endsequence
   sequence s_nmi_out;
      dispatch_o & (vector_o == epr_pkg::VEC_NMI) & ~intack_o;
   endsequence

   nmi_first_a: assert property (s_both_req |=> s_nmi_out)
      else $error("nmi not taken before maskable");
   nmi_no_ack_a: assert property (intack_o |-> dispatch_o && vector_o != epr_pkg::VEC_NMI)
      else $error("acknowledge with wrong dispatch");
   maskable_irq_in_enable_a: assert property (
      intack_o |-> $past(flag_word[epr_pkg::FLAG_IF]) && !$past(nmi_active))
      else $error("maskable taken while disabled");
   nmi_latch_a: assert property (
      nmi_active & nmi_new & ~irq_return_op_i |=> nmi_pend && nmi_active)
      else $error("repeat nmi not latched");
   boundary_only_a: assert property (
      dispatch_o & !$past(take_nested) |-> $past(boundary_i))
      else $error("dispatch away from boundary");
   trap_first_a: assert property (
      evt_ok & ~take_nested & dbg_trap_i |=> dispatch_o && vector_o == epr_pkg::VEC_DEBUG)
      else $error("debug trap not first");
   dbl_page_a: assert property (
      take_nested & (disp_class == CLS_PAGE) |=> vector_o == epr_pkg::VEC_DFAULT)
      else $error("no double fault in page entry");
   dbl_seg_a: assert property (
      take_nested & (disp_class == CLS_SEG) & (nested_vec_i == epr_pkg::VEC_PAGE)
      |=> vector_o == epr_pkg::VEC_PAGE)
      else $error("page fault wrongly escalated");
   cop_err_a: assert property (
      dispatch_o & (vector_o == epr_pkg::VEC_COPERR) & !$past(take_nested)
      |-> $past(cop_err & ~wait_nm & ~esc_nm))
      else $error("coprocessor error order wrong");
   upper_low_a: assert property (
      exec_ok & far_jump_i |=> upper_addr_low_o [*2])
      else $error("upper lines not held low");
   reset_quiet_a: assert property (!exec_ok |=> !dispatch_o && !intack_o)
      else $error("dispatch before start");
endmodule : epr_ctrl

// file: dv/epr_src_model.sv
// epr_src_model: interrupt source and numeric coprocessor stand-in
`timescale 1ns/1ps
module epr_src_model (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic raise_nmi_i,
   input wire logic raise_irq_i,
   input wire logic err_i,
   input wire logic busy_i,
   input wire logic dispatch_i,
   input wire logic intack_i,
   input wire logic [7:0] vector_i,
   output logic maskable_irq_in_o,
   output logic nmi_o,
   output logic coproc_error_n_o,
   output logic coproc_busy_n_o
);
   // --------
   // requests
   // --------
   assign coproc_error_n_o = !err_i;
   assign coproc_busy_n_o = !busy_i;
   // a request stays up until the controller dispatches it
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         maskable_irq_in_o <= 1'h0;
         nmi_o <= 1'h0;
      end else begin
         if (raise_irq_i) begin
            maskable_irq_in_o <= 1'h1;
         end else if (dispatch_i && intack_i) begin
            maskable_irq_in_o <= 1'h0;
         end
         if (raise_nmi_i) begin
            nmi_o <= 1'h1;
         end else if (dispatch_i && vector_i == 8'h02) begin
            nmi_o <= 1'h0;
         end
      end
   end
endmodule : epr_src_model

// file: dv/epr_ctrl_tb.sv
// exception_priority_reset_control_tb: self-checking bench for epr_ctrl
`timescale 1ns/1ps
module exception_priority_reset_control_tb;
   // --------
   // signals
   // --------
   typedef struct packed {
      logic [13:0] ev;
      logic [4:0] len;
      logic [3:0] ctl;
      logic err;
      logic [7:0] vec;
      logic rst;
   } epr_row_s;
   parameter logic [31:0] TB_ID = 32'h00007C13; // arbitrary value
   logic core_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0] paddr_i, irq_vector_i, mem_seg_vec_i, nested_vec_i, vector_o;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [13:0] ev;
   logic [4:0] instr_len_i;
   logic boundary_i, irq_return_op_i, far_jump_i, nested_exc_i, er, hent, flaw, bist_seen = 1'h0;
   logic dispatch_o, intack_o, restartable_o, exec_enable_o, bist_run_o, upper_addr_low_o;
   logic [23:0] fetch_addr_o;
   logic mirq, nmi, err_n, busy_n, rnmi, rirq, err_cmd, busy_cmd;
   int failures = 0;
   int checks = 0;
   int n;
   epr_row_s rows [19] = '{
      '{14'h0003, 5'h02, 4'h8, 1'h0, 8'h01, 1'h0}, '{14'h0006, 5'h02, 4'h8, 1'h0, 8'h01, 1'h1},
      '{14'h001C, 5'h02, 4'h8, 1'h0, 8'h0B, 1'h1}, '{14'h0014, 5'h02, 4'h8, 1'h0, 8'h0D, 1'h1},
      '{14'h0030, 5'h02, 4'h8, 1'h0, 8'h0E, 1'h1}, '{14'h00A0, 5'h02, 4'h8, 1'h0, 8'h06, 1'h1},
      '{14'h0040, 5'h02, 4'h0, 1'h0, 8'h06, 1'h1}, '{14'h0000, 5'h10, 4'h8, 1'h0, 8'h0D, 1'h1},
      '{14'h0080, 5'h02, 4'h8, 1'h0, 8'h0D, 1'h1}, '{14'h0100, 5'h02, 4'hB, 1'h0, 8'h07, 1'h1},
      '{14'h0100, 5'h02, 4'h9, 1'h1, 8'h10, 1'h1}, '{14'h0200, 5'h02, 4'hC, 1'h0, 8'h07, 1'h1},
      '{14'h0200, 5'h02, 4'h9, 1'h0, 8'h07, 1'h1}, '{14'h0200, 5'h02, 4'h8, 1'h1, 8'h10, 1'h1},
      '{14'h0C00, 5'h02, 4'h8, 1'h0, 8'h0C, 1'h1}, '{14'h0800, 5'h02, 4'h8, 1'h0, 8'h0E, 1'h1},
      '{14'h1800, 5'h02, 4'h8, 1'h0, 8'h0E, 1'h0}, '{14'h2800, 5'h02, 4'h8, 1'h0, 8'h0E, 1'h0},
      '{14'h0400, 5'h02, 4'h8, 1'h0, 8'h0C, 1'h1}};
   logic [39:0] regs [9] = '{{8'h0C, 32'h0000FFF0}, {8'h10, 32'h0000F000},
      {8'h14, 32'hFFFF0000}, {8'h18, 32'h0000FFFF}, {8'h1C, 32'h00000000},
      {8'h20, 32'h0000FFFF}, {8'h04, 32'h00000002}, {8'h24, 32'h00000000}, {8'h28, TB_ID}};

   epr_ctrl #(.BIST_CYCLES(16), .COMP_STEP_ID(TB_ID)) u_epr_ctrl (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .maskable_irq_in_i(mirq), .nmi_i(nmi),
      .irq_vector_i(irq_vector_i), .coproc_error_n_i(err_n), .coproc_busy_n_i(busy_n),
      .selftest_flaw_i(flaw), .boundary_i(boundary_i), .dbg_trap_i(ev[0]),
      .dbg_fault_i(ev[1]), .fetch_seg_fault_i(ev[2]), .fetch_seg_np_i(ev[3]),
      .fetch_page_fault_i(ev[4]), .illegal_op_i(ev[5]), .prot_only_i(ev[6]),
      .instr_len_i(instr_len_i), .priv_viol_i(ev[7]), .wait_op_i(ev[8]),
      .coproc_escape_op_i(ev[9]), .mem_seg_fault_i(ev[10]), .mem_seg_vec_i(mem_seg_vec_i),
      .mem_page_fault_i(ev[11]), .irq_return_op_i(irq_return_op_i), .far_jump_i(far_jump_i),
      .nested_exc_i(nested_exc_i), .nested_vec_i(nested_vec_i), .handler_entered_i(hent),
      .tss_partial_i(ev[12]), .coproc_wrap_i(ev[13]), .dispatch_o(dispatch_o),
      .vector_o(vector_o), .intack_o(intack_o), .restartable_o(restartable_o),
      .exec_enable_o(exec_enable_o), .bist_run_o(bist_run_o),
      .upper_addr_low_o(upper_addr_low_o), .fetch_addr_o(fetch_addr_o));

   epr_src_model u_epr_src_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .raise_nmi_i(rnmi), .raise_irq_i(rirq), .err_i(err_cmd), .busy_i(busy_cmd),
      .dispatch_i(dispatch_o), .intack_i(intack_o), .vector_i(vector_o),
      .maskable_irq_in_o(mirq), .nmi_o(nmi), .coproc_error_n_o(err_n),
      .coproc_busy_n_o(busy_n));

   // --------
   // tasks
   // --------
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel_i <= 1'h1;
      penable_i <= 1'h0;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'h1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'h1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb

   // drive one boundary; outputs of its dispatch are readable on return
   task automatic bnd(input logic [13:0] e, input logic [4:0] l);
      @(posedge core_clk_i);
      ev <= e;
      instr_len_i <= l;
      boundary_i <= 1'h1;
      @(posedge core_clk_i);
      ev <= 14'h0;
      instr_len_i <= 5'h02;
      boundary_i <= 1'h0;
      @(posedge core_clk_i);
   endtask : bnd

   // one-cycle pulse on {hent, irq_return_op_i, rnmi, far_jump_i, nested_exc_i}
   task automatic pulse(input logic [4:0] m);
      @(posedge core_clk_i);
      {hent, irq_return_op_i, rnmi, far_jump_i, nested_exc_i} <= m;
      @(posedge core_clk_i);
      {hent, irq_return_op_i, rnmi, far_jump_i, nested_exc_i} <= 5'h00;
   endtask : pulse

   task automatic nest(input logic [7:0] v, input logic [7:0] exp);
      nested_vec_i <= v;
      pulse(5'h01);
      @(posedge core_clk_i);
      chk({dispatch_o, vector_o}, {1'h1, exp});
   endtask : nest

   task automatic wait_exec;
      n = 0;
      while (exec_enable_o !== 1'h1 && n < 3000) begin
         @(posedge core_clk_i);
         n++;
      end
   endtask : wait_exec

   initial begin
      core_clk_i = 1'h0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   initial begin
      #(40 * 20000);
      failures++;
      tally_and_finish();
   end

   always @(posedge core_clk_i) begin
      if (bist_run_o === 1'h1) bist_seen <= 1'h1;
   end

   // --------
   // sequence
   // --------
   initial begin
      {rstn_i, psel_i, penable_i, pwrite_i, boundary_i, irq_return_op_i, far_jump_i} = 7'h0;
      {nested_exc_i, rnmi, rirq, err_cmd, busy_cmd, hent, flaw} = 7'h0;
      {paddr_i, pwdata_i, ev, nested_vec_i} = 62'h0;
      irq_vector_i = 8'h41;
      mem_seg_vec_i = 8'h0C;
      instr_len_i = 5'h02;
      repeat (9) @(posedge core_clk_i);
      bnd(14'h0001, 5'h02);
      chk({dispatch_o, exec_enable_o}, 2'h0);
      chk(fetch_addr_o, 24'hFFFFF0);
      rstn_i <= 1'h1;
      bnd(14'h0001, 5'h02);
      chk(dispatch_o, 1'h0);
      wait_exec();
      chk(n + 3 >= 350 && n + 3 <= 450, 1'h1);
      apb(1'h1, 8'h0C, 32'h0);
      foreach (regs[i]) begin
         apb(1'h0, regs[i][39:32], 32'h0);
         chk({er, rd}, {1'h0, regs[i][31:0]});
      end
      apb(1'h0, 8'h3C, 32'h0);
      chk({er, rd}, {1'h1, 32'h0});
      foreach (rows[i]) begin
         apb(1'h1, epr_pkg::ADDR_CTRL, {28'h0, rows[i].ctl});
         err_cmd <= rows[i].err;
         bnd(rows[i].ev, rows[i].len);
         chk({dispatch_o, restartable_o, vector_o}, {1'h1, rows[i].rst, rows[i].vec});
      end
      err_cmd <= 1'h0;
      bnd(14'h0008 | 14'h0004, 5'h02);
      nest(8'h0E, 8'h0E);
      nest(8'h0D, 8'h08);
      bnd(14'h0004, 5'h02);
      nest(8'h0C, 8'h08);
      bnd(14'h0004, 5'h02);
      pulse(5'h10);
      pulse(5'h01);
      @(posedge core_clk_i);
      chk(dispatch_o, 1'h0);
      chk(upper_addr_low_o, 1'h0);
      pulse(5'h02);
      @(posedge core_clk_i);
      chk({upper_addr_low_o, fetch_addr_o}, {1'h1, 24'hFFFFF0});
      apb(1'h1, epr_pkg::ADDR_FLAGS, 32'h00000202);
      rnmi <= 1'h1;
      rirq <= 1'h1;
      @(posedge core_clk_i);
      rnmi <= 1'h0;
      rirq <= 1'h0;
      repeat (3) @(posedge core_clk_i);
      chk(dispatch_o, 1'h0);
      bnd(14'h0, 5'h02);
      chk({dispatch_o, intack_o, vector_o}, {2'h2, 8'h02});
      apb(1'h0, epr_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h00000002);
      pulse(5'h04);
      bnd(14'h0, 5'h02);
      chk(dispatch_o, 1'h0);
      pulse(5'h08);
      bnd(14'h0, 5'h02);
      chk({dispatch_o, intack_o, vector_o}, {2'h2, 8'h02});
      pulse(5'h08);
      bnd(14'h0, 5'h02);
      chk(dispatch_o, 1'h0);
      apb(1'h1, epr_pkg::ADDR_FLAGS, 32'h00000202);
      bnd(14'h0, 5'h02);
      chk({dispatch_o, intack_o, vector_o}, {2'h3, 8'h41});
      rstn_i <= 1'h0;
      busy_cmd <= 1'h1;
      flaw <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'h1;
      repeat (2) @(posedge core_clk_i);
      busy_cmd <= 1'h0;
      wait_exec();
      apb(1'h0, epr_pkg::ADDR_ACC, 32'h0);
      chk({bist_seen, exec_enable_o, rd}, {2'h3, 32'h1});
      tally_and_finish();
   end
endmodule : exception_priority_reset_control_tb
